// *** pkg/spi_err_params.svh ***
// Offsets, field positions, reset values and constants of the SPI error monitor.
// Assumes a 32-bit AHB-Lite slave with one register per aligned word.
`ifndef SPI_ERR_PARAMS_SVH
`define SPI_ERR_PARAMS_SVH

// =============================================
// Register indexes, byte address is four times the index
`define IDX_ERR_STATUS   16'h2301
`define IDX_IRQ_STATUS   16'h2310
`define IDX_IRQ_ENABLE   16'h2311
`define IDX_IRQ_CLEAR    16'h2312

// =============================================
// Field positions inside the status byte
`define BIT_RECEIVE_FIFO_OVERFLOW    0
`define BIT_TRANSMIT_FIFO_UNDERFLOW    1
`define BIT_TRANSMIT_FIFO_OVERFLOW    2
`define BIT_RX_UNEXP     3
`define BIT_TX_UNEXP     4
`define BIT_CLR_ERR      5
`define BIT_FRAME_FORMAT_ERROR      6
`define FLAG_COUNT       7

// =============================================
// Reset values and constants
`define RST_ERR_STATUS   7'h00
`define RST_IRQ_ENABLE   7'h00
`define MASK_BYTE        8'hFF
`define BITS_PER_BYTE    4'h8
`define SYS_CLK_MHZ      25

`endif

// *** pkg/spi_err_pkg.sv ***
// Types shared by the SPI error monitor files.
// Assumes spi_err_params.svh is included by the users for constants.
package spi_err_pkg;

   // =============================================
   // Bus transfer types and the flag vector
   typedef enum logic [1:0] {
      TransIdle,
      TransBusy,
      TransNonseq,
      TransSeq
   } htrans_t;

   typedef logic [6:0] flags_t;

endpackage

// *** design/spi_sticky_flags.sv ***
// Sticky flag bank: hardware sets, a clear strobe clears, set beats clear.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module spi_sticky_flags #(
   parameter int WIDTH = 7
) (
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] setBits,
   input  wire logic [WIDTH-1:0] clrBits,
   output var  logic [WIDTH-1:0] flags_q
);

   // =============================================
   // Storage
   logic [WIDTH-1:0] flags_d;

   // A flag raised in its own clear cycle survives, so no event is lost
   always_comb begin
      flags_d = (flags_q & ~clrBits) | setBits;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         flags_q <= '0;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule
`default_nettype wire

// *** design/spi_target_error_monitor.sv ***
// Error detection and recovery for the SPI target port facing the host.
// Assumes SPI pins and FIFO status inputs are synchronous to sys_clk,
// SCLK well below sys_clk/4, SPI mode 0 (sample on rise, shift on fall).
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
`include "spi_err_params.svh"

module spi_target_error_monitor (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   // SPI target pins
   input  wire logic        sclk,
   input  wire logic        csN,
   input  wire logic        mosi,
   output var  logic        miso,
   output var  logic        spiReady,
   // FIFO datapath status
   input  wire logic        hostReading,
   input  wire logic [7:0]  txData,
   input  wire logic        hostRdFifoEmpty,
   input  wire logic        hostWrFifoFull,
   input  wire logic        rxAcceptFull,
   input  wire logic        rxDataReady,
   input  wire logic        txTimeout,
   input  wire logic        lateTxData,
   input  wire logic        linkClearValid,
   input  wire logic        linkClearBad,
   output var  logic [7:0]  rxByte,
   output var  logic        rxByteWrite,
   output var  logic        txDataPop,
   output var  logic        storeBlocked,
   output var  logic        irq
);

   // =============================================
   // Helpers
   function automatic logic [31:0] byteAddr(input logic [15:0] idx);
      byteAddr = {14'h0000, idx, 2'h0};
   endfunction

   // =============================================
   // SPI edge and frame tracking
   logic       sclkPrev_q;
   logic       csPrev_q;
   logic [2:0] bitCnt_q;
   logic [7:0] shiftIn_q;
   logic [7:0] shiftOut_q;
   logic       maskActive_q;
   logic       sclkRise;
   logic       sclkFall;
   logic       csFall;
   logic       csRise;
   logic       byteDone;
   logic       byteLoad;
   logic       fault;

   assign sclkRise = sclk & ~sclkPrev_q & ~csN;
   assign sclkFall = ~sclk & sclkPrev_q & ~csN;
   assign csFall   = ~csN & csPrev_q;
   assign csRise   = csN & ~csPrev_q;
   assign byteDone = sclkRise & (bitCnt_q == 3'h7);
   assign byteLoad = csFall | (byteDone & ~csN);

   // Previous pin levels for edge detection
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         sclkPrev_q <= 1'b0;
         csPrev_q   <= 1'b1;
      end else begin
         sclkPrev_q <= sclk;
         csPrev_q   <= csN;
      end
   end

   // Bit counter restarts each frame, so a short byte shows at frame end
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         bitCnt_q <= 3'h0;
      end else if (csFall) begin
         bitCnt_q <= 3'h0;
      end else if (sclkRise) begin
         bitCnt_q <= bitCnt_q + 3'h1;
      end
   end

   // Receive shifter
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         shiftIn_q <= 8'h00;
      end else if (sclkRise) begin
         shiftIn_q <= {shiftIn_q[6:0], mosi};
      end
   end

   // Mask decision is taken only at load time, never mid-byte
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         maskActive_q <= 1'b0;
      end else if (byteLoad) begin
         maskActive_q <= fault | (hostReading & hostRdFifoEmpty);
      end
   end

   // Transmit shifter, a running byte is finished before FF replaces it
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         shiftOut_q <= `MASK_BYTE;
      end else if (byteLoad) begin
         if (fault || (hostReading && hostRdFifoEmpty)) begin
            shiftOut_q <= `MASK_BYTE;
         end else begin
            shiftOut_q <= txData;
         end
      end else if (sclkFall && bitCnt_q != 3'h0) begin // Fall after a load keeps the MSB
         shiftOut_q <= {shiftOut_q[6:0], 1'b1};
      end
   end

   // MISO leads with the MSB of the loaded byte
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         miso <= 1'b1;
      end else begin
         miso <= shiftOut_q[7];
      end
   end

   // =============================================
   // Fault events
   spi_err_pkg::flags_t events;
   spi_err_pkg::flags_t errFlags_q;
   spi_err_pkg::flags_t clrVec;

   always_comb begin
      events = '0;
      events[`BIT_FRAME_FORMAT_ERROR]   = csRise & (bitCnt_q != 3'h0);
      events[`BIT_CLR_ERR]   = linkClearBad;
      events[`BIT_TX_UNEXP]  = lateTxData & txTimeout;
      events[`BIT_RX_UNEXP]  = (csFall & ~spiReady)
                             | (byteDone & hostReading & ~rxDataReady);
      events[`BIT_TRANSMIT_FIFO_OVERFLOW] = byteDone & ~hostReading & hostWrFifoFull;
      events[`BIT_TRANSMIT_FIFO_UNDERFLOW] = byteLoad & hostReading & hostRdFifoEmpty;
      events[`BIT_RECEIVE_FIFO_OVERFLOW] = byteDone & ~hostReading & rxAcceptFull;
   end

   // Only a valid link clear wipes the flags; a malformed one only sets the BIT_CLR_ERR flag
   assign clrVec = {`FLAG_COUNT{linkClearValid}};

   spi_sticky_flags #(
      .WIDTH(`FLAG_COUNT)
   ) uErrFlags (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .setBits (events),
      .clrBits (clrVec),
      .flags_q (errFlags_q)
   );

   // The link-clear error alone leaves ready and data untouched
   assign fault = |((errFlags_q | events) & ~(7'h01 << `BIT_CLR_ERR));

   // Ready and store block follow the fault in the same cycle as its flag
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         spiReady     <= 1'b1;
         storeBlocked <= 1'b0;
      end else begin
         spiReady     <= ~fault;
         storeBlocked <= fault;
      end
   end

   // FIFO write strobes are suppressed while faulted
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rxByte      <= 8'h00;
         rxByteWrite <= 1'b0;
         txDataPop   <= 1'b0;
      end else begin
         rxByte      <= {shiftIn_q[6:0], mosi};
         rxByteWrite <= byteDone & ~hostReading & ~fault;
         txDataPop   <= byteLoad & hostReading & ~fault & ~hostRdFifoEmpty;
      end
   end

   // =============================================
   // Interrupt bank
   spi_err_pkg::flags_t irqStat_q;
   spi_err_pkg::flags_t irqEn_q;
   spi_err_pkg::flags_t irqClr;

   spi_sticky_flags #(
      .WIDTH(`FLAG_COUNT)
   ) uIrqFlags (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .setBits (events),
      .clrBits (irqClr),
      .flags_q (irqStat_q)
   );

   // Registered so the pin never glitches on a decode
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_q & irqEn_q);
      end
   end

   // =============================================
   // AHB-Lite slave, zero wait states, always OKAY
   logic        wrPend_q;
   logic [31:0] wrAddr_q;
   logic        addrOk;

   assign addrOk = hsel & hready & htrans[1];

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Write address held for the data phase
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 32'h0000_0000;
      end else begin
         wrPend_q <= addrOk & hwrite;
         wrAddr_q <= haddr;
      end
   end

   // Enable register steers the interrupt gate
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         irqEn_q <= `RST_IRQ_ENABLE;
      end else if (wrPend_q && wrAddr_q == byteAddr(`IDX_IRQ_ENABLE)) begin
         irqEn_q <= hwdata[6:0];
      end
   end

   // Write-one-to-clear strobes; the status byte itself ignores writes
   always_comb begin
      irqClr = '0;
      if (wrPend_q && wrAddr_q == byteAddr(`IDX_IRQ_CLEAR)) begin
         irqClr = hwdata[6:0];
      end
   end

   // Read data captured at the address phase, unmapped reads give zero
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         hrdata <= 32'h0000_0000;
      end else if (addrOk && !hwrite) begin
         unique case (haddr)
            byteAddr(`IDX_ERR_STATUS): hrdata <= {25'h0000000, errFlags_q};
            byteAddr(`IDX_IRQ_STATUS): hrdata <= {25'h0000000, irqStat_q};
            byteAddr(`IDX_IRQ_ENABLE): hrdata <= {25'h0000000, irqEn_q};
            default:                   hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // =============================================
   // Assertions
   sequence s_faultSeen;
      fault;
   endsequence

   sequence s_loadAfter;
      ##[1:300] byteLoad;
   endsequence

   a_fmt_flag_set: assert property (@(posedge sys_clk) disable iff (!reset_n)
      csRise && bitCnt_q != 3'h0 |=> errFlags_q[`BIT_FRAME_FORMAT_ERROR])
      else $error("frame format flag missed");

   a_bad_clear_ignored: assert property (@(posedge sys_clk) disable iff (!reset_n)
      linkClearBad && !linkClearValid && errFlags_q[`BIT_TX_UNEXP]
      |=> errFlags_q[`BIT_TX_UNEXP] && errFlags_q[`BIT_CLR_ERR])
      else $error("malformed clear acted");

   a_rx_unexp_start: assert property (@(posedge sys_clk) disable iff (!reset_n)
      csFall && !spiReady |=> errFlags_q[`BIT_RX_UNEXP])
      else $error("start while not ready not flagged");

   a_tx_of_flag: assert property (@(posedge sys_clk) disable iff (!reset_n)
      byteDone && !hostReading && hostWrFifoFull |=> errFlags_q[`BIT_TRANSMIT_FIFO_OVERFLOW] && !rxByteWrite)
      else $error("write overflow not handled");

   a_no_store_fault: assert property (@(posedge sys_clk) disable iff (!reset_n)
      storeBlocked && !linkClearValid && !$past(linkClearValid) |=> !rxByteWrite && !txDataPop)
      else $error("store while faulted");

   a_mask_after_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
      s_faultSeen ##0 byteLoad |=> shiftOut_q == `MASK_BYTE ##1 miso)
      else $error("mask byte not loaded");

   a_mask_on_boundary: assert property (@(posedge sys_clk) disable iff (!reset_n)
      !byteLoad |=> $stable(maskActive_q))
      else $error("mask changed mid byte");

   a_ready_low_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
      (errFlags_q[`BIT_RECEIVE_FIFO_OVERFLOW] && !linkClearValid) |=> !spiReady)
      else $error("ready rose during fault");

   a_clear_wipes: assert property (@(posedge sys_clk) disable iff (!reset_n)
      linkClearValid && events == '0 |=> errFlags_q == '0 ##1 spiReady)
      else $error("valid clear did not recover");

   a_uf_returns_ff: assert property (@(posedge sys_clk) disable iff (!reset_n)
      byteLoad && hostReading && hostRdFifoEmpty |=> shiftOut_q == `MASK_BYTE
      && errFlags_q[`BIT_TRANSMIT_FIFO_UNDERFLOW])
      else $error("underflow did not return FF");

endmodule
`default_nettype wire

// *** tb/spi_host_model.sv ***
// Host controller model driving the SPI target pins in mode 0.
// Assumes it shares sys_clk with the target; pins change just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
   input  wire logic sys_clk,
   input  wire logic miso,
   input  wire logic spiReady,
   output var  logic sclk,
   output var  logic csN,
   output var  logic mosi,
   output var  logic stuck
);
   // =============================================
   // Idle pins: clock parked low between frames, select released
   initial begin
      sclk  = 1'b0;
      csN   = 1'b1;
      mosi  = 1'b0;
      stuck = 1'b0;
   end

   // =============================================
   // One frame, MSB first, both clock phases four cycles long
   // A rude frame ignores the ready level on purpose
   task automatic frame(input int nbits, input logic [15:0] dout, input logic rude,
                        output logic [15:0] din);
      int i;
      i = 0;
      while (!rude && spiReady !== 1'b1 && i < 200) begin
         @(posedge sys_clk);
         i++;
      end
      if (i == 200) stuck = 1'b1;
      din = 16'h0000;
      @(posedge sys_clk);
      csN <= 1'b0;
      for (i = nbits - 1; i >= 0; i--) begin
         repeat (4) @(posedge sys_clk);
         sclk <= 1'b0; // Mode 0: data changes on the falling clock
         mosi <= dout[i];
         repeat (4) @(posedge sys_clk);
         sclk <= 1'b1;
         din  = {din[14:0], miso}; // Host samples on the rising clock
      end
      repeat (4) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (4) @(posedge sys_clk);
      csN  <= 1'b1;
      mosi <= ~mosi; // Released line must not keep showing the last bit
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

// *** tb/tb_spi_target_error_monitor.sv ***
// Self-checking bench for the SPI target error monitor.
// Assumes the host model is compiled first and the params header is on the include path.
`timescale 1ns/10ps
`default_nettype none
`include "spi_err_params.svh"

module tb_spi_target_error_monitor;
   localparam logic [31:0] A_ST  = 32'(`IDX_ERR_STATUS) << 2;
   localparam logic [31:0] A_IST = 32'(`IDX_IRQ_STATUS) << 2;
   localparam logic [31:0] A_IEN = 32'(`IDX_IRQ_ENABLE) << 2;
   localparam logic [31:0] A_ICL = 32'(`IDX_IRQ_CLEAR) << 2;
   logic        sys_clk, reset_n, hsel, hwrite, hreadyout, miso, spiReady, sclk, csN, mosi;
   logic        hostReading, hostRdFifoEmpty, hostWrFifoFull, rxAcceptFull, rxDataReady;
   logic        txTimeout, lateTxData, linkClearValid, linkClearBad, stuck;
   logic        rxByteWrite, txDataPop, storeBlocked, irq, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  txData, rxByte, lastRx;
   logic [15:0] got;
   int          n_mismatch, comparisons, nWr, nPop, k;

   spi_target_error_monitor u_dut (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .sclk, .csN,
      .mosi, .miso, .spiReady, .hostReading, .txData, .hostRdFifoEmpty, .hostWrFifoFull,
      .rxAcceptFull, .rxDataReady, .txTimeout, .lateTxData, .linkClearValid, .linkClearBad,
      .rxByte, .rxByteWrite, .txDataPop, .storeBlocked, .irq);
   spi_host_model u_host (.sys_clk, .miso, .spiReady, .sclk, .csN, .mosi, .stuck);

   // =============================================
   // Clock and FIFO-side monitors
   initial sys_clk = 1'b0;
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (rxByteWrite === 1'b1) begin
         nWr++;
         lastRx = rxByte;
      end
      if (txDataPop === 1'b1) nPop++;
   end
   initial begin
      repeat (100000) @(posedge sys_clk);
      n_mismatch++; // Watchdog: a hung run is a failure
      stop_test();
   end

   // =============================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic waitReady();
      int i;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) return;
      end
      n_mismatch++;
      stop_test();
   endtask
   // Single word transfer: address phase held until ready, then data phase
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= spi_err_pkg::TransNonseq;
      waitReady();
      htrans <= spi_err_pkg::TransIdle;
      hsel   <= 1'b0;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask
   task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic recover();
      @(posedge sys_clk);
      linkClearValid <= 1'b1;
      @(posedge sys_clk);
      linkClearValid <= 1'b0;
      settle();
   endtask

   // =============================================
   // Main sequence
   initial begin
      {reset_n, hsel, hwrite, hostReading, hostRdFifoEmpty, hostWrFifoFull} = 6'h00;
      {rxAcceptFull, txTimeout, lateTxData, linkClearValid, linkClearBad} = 5'h00;
      {haddr, hwdata, htrans, hsize, rxDataReady, txData} = {64'h0, 2'h0, 3'h2, 1'b1, 8'h3C};
      {n_mismatch, comparisons, nWr, nPop} = 0;
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      check(32'(miso), 32'h1);
      check(32'(spiReady), 32'h1);
      check(32'(hresp), 32'h0); // Slave always answers OKAY
      bus(1'b1, A_ST, 32'h0000_007F); // Status ignores writes
      rdchk(A_ST, 32'h0);
      rdchk(A_IEN, 32'h0);
      rdchk(32'h0000_0100, 32'h0);
      // Clean write frame stores one byte; a two-byte read frame pops once per
      // loaded byte, the load after its last bit included
      u_host.frame(8, 16'h0096, 1'b0, got);
      check(32'(nWr), 32'h1);
      check(32'(lastRx), 32'h96);
      hostReading <= 1'b1;
      u_host.frame(16, 16'h0000, 1'b0, got);
      check(32'(got), 32'h3C3C); // Second byte keeps its MSB
      check(32'(nPop), 32'h3);
      // Late data lands mid-byte: that byte finishes, the next one is masked
      txTimeout <= 1'b1;
      fork
         u_host.frame(16, 16'h0000, 1'b0, got);
         begin
            repeat (20) @(posedge sys_clk);
            lateTxData <= 1'b1;
            @(posedge sys_clk);
            lateTxData <= 1'b0;
         end
      join
      check(32'(got), 32'h3CFF);
      check(32'(nPop), 32'h4);
      txTimeout   <= 1'b0;
      hostReading <= 1'b0;
      settle();
      rdchk(A_ST, 32'h1 << `BIT_TX_UNEXP);
      // Frame started while not ready, nothing stored
      u_host.frame(8, 16'h00A5, 1'b1, got);
      check(32'(nWr), 32'h1);
      @(posedge sys_clk);
      linkClearBad <= 1'b1;
      @(posedge sys_clk);
      linkClearBad <= 1'b0;
      settle();
      rdchk(A_ST, 32'h38);
      check(32'(spiReady), 32'h0);
      check(32'(irq), 32'h0); // Masked while enable is zero
      rdchk(A_IST, 32'h38);
      recover();
      rdchk(A_ST, 32'h0);
      check(32'(spiReady), 32'h1);
      bus(1'b1, A_IEN, 32'h0000_007F);
      settle();
      check(32'(irq), 32'h1);
      bus(1'b1, A_ICL, 32'h0000_007F);
      settle();
      check(32'(irq), 32'h0);
      // Each fault source in turn, then recovery
      for (k = 0; k < 7; k++) begin
         hostReading     <= (k == 1 || k == 3);
         rxAcceptFull    <= (k == 0);
         hostRdFifoEmpty <= (k == 1);
         hostWrFifoFull  <= (k == 2);
         rxDataReady     <= (k != 3);
         txTimeout       <= (k == 4);
         lateTxData      <= (k == 4);
         linkClearBad    <= (k == 5);
         @(posedge sys_clk);
         {lateTxData, linkClearBad} <= 2'b00;
         if (k < 4 || k == 6) u_host.frame((k == 6) ? 5 : 8, 16'h005A, 1'b0, got);
         {rxAcceptFull, hostRdFifoEmpty, hostWrFifoFull, rxDataReady, txTimeout} <= 5'b00010;
         settle();
         rdchk(A_ST, 32'h1 << k);
         if (k == 1) check(32'(got[7:0]), 32'hFF);
         check(32'(spiReady), 32'(k == 5));
         check(32'(storeBlocked), 32'(k != 5));
         check(32'(irq), 32'h1);
         recover();
         rdchk(A_ST, 32'h0);
         bus(1'b1, A_ICL, 32'h0000_007F);
         settle();
         check(32'(irq), 32'h0);
      end
      check(32'(stuck), 32'h0);
      stop_test();
   end
endmodule

`default_nettype wire
